// [design/spier_defs.svh]
/*
 * Offsets, field positions, reset values and fixed patterns of the
 * management register bank. Assumes clause-22 style five-bit register
 * addresses and sixteen-bit register data.
 */
`ifndef SPIER_DEFS_SVH
`define SPIER_DEFS_SVH

// Register offsets.
`define SPIER_REG_CTRL     5'h00
`define SPIER_REG_ID_HI    5'h02
`define SPIER_REG_ID_LO    5'h03
`define SPIER_REG_ADV      5'h04
`define SPIER_REG_EXT      5'h0f
`define SPIER_REG_GEN      5'h12

// Field positions.
`define SPIER_GEN_RD_EN    0
`define SPIER_CTRL_AN_EN   12

// Register 0 reset, writable bits and bits that always read one; register 4 reset.
`define SPIER_CTRL_RESET   16'h1540
`define SPIER_CTRL_WMASK   16'h9e20
`define SPIER_CTRL_FIXED   16'h0140
`define SPIER_ADV_RESET    16'h0001

// Extended status: only full-duplex 1000BASE-X is advertised. Register 18 enable resets to zero.
`define SPIER_EXT_VALUE    16'h8000
`define SPIER_GEN_RESET    1'h0

// Frame opcodes and bit counts.
`define SPIER_OP_READ      2'h2
`define SPIER_OP_WRITE     2'h1
`define SPIER_HDR_LAST     4'hb
`define SPIER_DATA_LAST    4'hf

`endif

// [design/spier_pkg.sv]
/*
 * Types shared by the management register bank and its helpers.
 * Assumes the constants header is included by each user.
 */
package spier_pkg;

   // Build-time variant of the device.
   typedef enum logic {
      SPIER_MAC_SIDE_VARIANT = 1'b0,
      SPIER_PHY_SIDE_VARIANT = 1'b1
   } spier_variant_t;

   // Management frame receiver states.
   typedef enum logic [2:0] {
      S_PRE   = 3'b000,
      S_ONE   = 3'b001,
      S_START = 3'b010,
      S_HDR   = 3'b011,
      S_TA    = 3'b100,
      S_DATA  = 3'b101
   } spier_state_t;

   // Contents of control register 0 and advertisement register 4.
   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] adv;
   } spier_cfg_t;

endpackage

// [design/spier_rd_gate.sv]
/*
 * Gates the running disparity errors reported by the code-group
 * decoder with the enable from the generic control register.
 * Assumes the decoder runs on the same clock.
 */
`timescale 1ns/1ps
module spier_rd_gate
   import spier_pkg::*;
(
   // Clock and reset.
   input  wire logic clk_in,
   input  wire logic resetn_in,
   // Enable and decoder flag.
   input  wire logic enable_in,
   input  wire logic rd_err_in,
   // Qualified error.
   output logic      rd_err_out
);

   // With checking off the decoder flag is dropped entirely.
   wire rd_err_nxt = enable_in & rd_err_in; // RULE5

   // Registered so the top output comes straight from a flop.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rd_err_out <= 1'b0;
      end else begin
         rd_err_out <= rd_err_nxt;
      end
   end

endmodule

// [design/spier_regs.sv]
/*
 * Management register bank of a four-port serial gigabit PCS: the
 * identifier, extended status, generic control and the build options,
 * reached by a station manager over the management pins and, for
 * registers 0 and 4, by a separate configuration port.
 *
 * Assumes MDC at most a tenth of CLOCK_IN, so that every MDC phase spans
 * several system clocks after the three-stage synchroniser; a faster MDC
 * would move a data bit before its sampling edge is seen here. Assumes a
 * pull-up on the shared management wire, so a released wire reads one,
 * and a code-group decoder on the same clock for the disparity flag.
 */
// How it works
// RULE1 - Registers 2 and 3 read a fixed organisation, model and revision identifier.
// RULE2 - Register 15 bit 15 always reads one for full-duplex 1000BASE-X.
// RULE3 - Register 15 bits 14 to 0 always read zero.
// RULE4 - Register 18 holds a read/write disparity enable in bit 0, reset zero, zeros above.
// RULE5 - With that enable at zero the receiver performs no running disparity checking.
// RULE6 - A build option, on by default, includes the management pins.
// RULE7 - A separate configuration port programs registers 0 and 4 beside the management pins.
// RULE8 - A build option, on by default, includes auto-negotiation.
// RULE9 - The MAC-side variant always faces its client through GMII.
// RULE10 - The PHY-side variant picks GMII or MII for its client at build time.
// RULE11 - Defaults are MAC-side, management included, auto-negotiation included and GMII.
// RULE12 - Writes to constant or reserved bits of registers 2, 3, 15 and 18 change nothing.
`timescale 1ns/1ps
`include "spier_defs.svh"
module spier_regs
   import spier_pkg::*;
#(
   parameter spier_variant_t VARIANT     = SPIER_MAC_SIDE_VARIANT, // RULE11
   parameter bit             MGMT_INCL   = 1'b1,                   // RULE6
   parameter bit             AN_INCL     = 1'b1,                   // RULE8
   parameter bit             CLIENT_GMII = 1'b1,
   // Identity values are arbitrary.
   parameter logic [21:0]    ORG_ID      = 22'h0a5a5,
   parameter logic [5:0]     MODEL_ID    = 6'h15,
   parameter logic [3:0]     REV_ID      = 4'h3
) (
   // Clock and reset.
   input  wire logic        CLOCK_IN,
   input  wire logic        RESETN_IN,
   // Management pins.
   input  wire logic        MDC_IN,
   input  wire logic        MDIO_IN,
   output logic             MDIO_OUT,
   output logic             MDIO_OE_N_OUT,
   input  wire logic [4:0]  PHYAD_IN,
   // Configuration port for registers 0 and 4.
   input  wire spier_cfg_t  CONFIG_IN,
   input  wire logic        CONFIG_VALID_IN,
   output spier_cfg_t       CFG_OUT,
   // Disparity checking.
   input  wire logic        RD_ERR_IN,
   output logic             RD_CHECK_EN_OUT,
   output logic             RD_ERR_OUT,
   // Build option status.
   output logic             MAC_SIDE_OUT,
   output logic             CLIENT_GMII_OUT,
   output logic             AN_ACTIVE_OUT
);

   // Synchronised pins and clock edge detection.
   logic [1:0] pins_s;
   logic       mdc_d_r;

   spier_sync #(.W(2)) u_sync (
      .clk_in    (CLOCK_IN),
      .resetn_in (RESETN_IN),
      .d_in      ({MDC_IN, MDIO_IN}),
      .q_out     (pins_s)
   );

   // Without the management option no edge is ever seen, so the sequencer
   // stays in its idle hunt and the wire is never driven.
   wire mdc_s    = pins_s[1];
   wire mdio_s   = pins_s[0];
   wire mdc_rise = mdc_s & ~mdc_d_r & MGMT_INCL; // RULE6

   // Frame state.
   spier_state_t st_r;
   spier_state_t st_nxt;
   logic [3:0]   cnt_r;
   logic [3:0]   cnt_nxt;
   logic [15:0]  sh_r;
   logic [15:0]  sh_nxt;
   logic [11:0]  hdr_r;
   logic [11:0]  hdr_nxt;
   logic [15:0]  tx_r;
   logic [15:0]  tx_nxt;
   logic         mdo_nxt;
   logic         oen_nxt;
   logic         wr_go;

   // Register state.
   spier_cfg_t   cfg_r;
   logic         rd_en_r;

   // Header fields of the frame in flight.
   wire [1:0]  op      = hdr_r[11:10];
   wire [4:0]  regad   = hdr_r[4:0];
   wire        hit     = (hdr_r[9:5] == PHYAD_IN);
   wire        rd_hit  = hit & (op == `SPIER_OP_READ);
   wire        wr_hit  = hit & (op == `SPIER_OP_WRITE);
   wire [15:0] wdata   = {sh_r[14:0], mdio_s};

   // Address decode.
   wire sel_ctrl  = (regad == `SPIER_REG_CTRL);
   wire sel_id_hi = (regad == `SPIER_REG_ID_HI);
   wire sel_id_lo = (regad == `SPIER_REG_ID_LO);
   wire sel_adv   = (regad == `SPIER_REG_ADV);
   wire sel_ext   = (regad == `SPIER_REG_EXT);
   wire sel_gen   = (regad == `SPIER_REG_GEN);

   // Fixed read values and the register 18 value; unmapped addresses read zero.
   wire [15:0] id_hi_val = ORG_ID[21:6];                     // RULE1
   wire [15:0] id_lo_val = {ORG_ID[5:0], MODEL_ID, REV_ID};  // RULE1
   wire [15:0] ext_val   = `SPIER_EXT_VALUE;                 // RULE2 RULE3
   wire [15:0] gen_val   = {15'h0000, rd_en_r};              // RULE4

   // Read data is chosen here and copied into the shift register at the
   // second turnaround edge, so a register that changes in mid-frame
   // cannot tear the answer.
   wire [15:0] rdata =
      sel_ctrl  ? cfg_r.ctrl :
      sel_id_hi ? id_hi_val  :
      sel_id_lo ? id_lo_val  :
      sel_adv   ? cfg_r.adv  :
      sel_ext   ? ext_val    :
      sel_gen   ? gen_val    : 16'h0000;

   // Only these three write strobes exist; identifier and extended
   // status writes decode to nothing.
   wire wr_ctrl = wr_go & sel_ctrl;
   wire wr_adv  = wr_go & sel_adv;
   wire wr_gen  = wr_go & sel_gen; // RULE12

   // Register 0 keeps its constant bits whatever is written.
   wire [15:0] ctrl_w = (wdata & `SPIER_CTRL_WMASK) | `SPIER_CTRL_FIXED;
   wire [15:0] cfg_ctrl_w =
      (CONFIG_IN.ctrl & `SPIER_CTRL_WMASK) | `SPIER_CTRL_FIXED;

   // Frame sequencer, advanced once per synchronised MDC rising edge.
   // Output changes follow the edge by a few clocks, well inside the
   // MDC period the station allows before it samples.
   always_comb begin
      st_nxt  = st_r;
      cnt_nxt = cnt_r;
      sh_nxt  = sh_r;
      hdr_nxt = hdr_r;
      tx_nxt  = tx_r;
      mdo_nxt = MDIO_OUT;
      oen_nxt = MDIO_OE_N_OUT;
      wr_go   = 1'b0;
      if (mdc_rise) begin
         unique case (st_r)
            S_PRE: begin
               oen_nxt = 1'b1;
               if (mdio_s) begin
                  st_nxt = S_ONE;
               end
            end
            // A single idle one is accepted, so short preambles work.
            S_ONE: begin
               if (!mdio_s) begin
                  st_nxt = S_START;
               end
            end
            // The second start bit must be one; anything else drops back to
            // the idle hunt rather than guessing at the frame.
            S_START: begin
               cnt_nxt = 4'h0;
               st_nxt  = mdio_s ? S_HDR : S_PRE;
            end
            S_HDR: begin
               sh_nxt  = {sh_r[14:0], mdio_s};
               cnt_nxt = cnt_r + 4'h1;
               if (cnt_r == `SPIER_HDR_LAST) begin
                  hdr_nxt = {sh_r[10:0], mdio_s};
                  cnt_nxt = 4'h0;
                  st_nxt  = S_TA;
               end
            end
            // Turnaround: the device drives zero for the second bit.
            S_TA: begin
               cnt_nxt = 4'h1;
               if (rd_hit && cnt_r == 4'h0) begin
                  mdo_nxt = 1'b0;
                  oen_nxt = 1'b0;
               end
               if (cnt_r == 4'h1) begin
                  cnt_nxt = 4'h0;
                  st_nxt  = S_DATA;
                  if (rd_hit) begin
                     mdo_nxt = rdata[15];
                     tx_nxt  = {rdata[14:0], 1'b0};
                  end
               end
            end
            S_DATA: begin
               sh_nxt  = {sh_r[14:0], mdio_s};
               cnt_nxt = cnt_r + 4'h1;
               // The wire is released right after the edge on which the
               // station takes bit 0, long before a next turnaround.
               if (cnt_r == `SPIER_DATA_LAST) begin
                  oen_nxt = 1'b1;
                  wr_go   = wr_hit;
                  st_nxt  = S_PRE;
               end else if (rd_hit) begin
                  mdo_nxt = tx_r[15];
                  tx_nxt  = {tx_r[14:0], 1'b0};
               end
            end
            default: begin
               oen_nxt = 1'b1;
               st_nxt  = S_PRE;
            end
         endcase
      end
   end

   // Sequencer registers.
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         st_r          <= S_PRE;
         cnt_r         <= 4'h0;
         sh_r          <= 16'h0000;
         hdr_r         <= 12'h000;
         tx_r          <= 16'h0000;
         mdc_d_r       <= 1'b0;
         MDIO_OUT      <= 1'b1;
         MDIO_OE_N_OUT <= 1'b1;
      end else begin
         st_r          <= st_nxt;
         cnt_r         <= cnt_nxt;
         sh_r          <= sh_nxt;
         hdr_r         <= hdr_nxt;
         tx_r          <= tx_nxt;
         mdc_d_r       <= mdc_s;
         MDIO_OUT      <= mdo_nxt;
         MDIO_OE_N_OUT <= oen_nxt;
      end
   end

   // Next values of registers 0 and 4. The configuration port takes
   // priority, since it is the path that works without management pins.
   wire [15:0] ctrl_nxt = CONFIG_VALID_IN ? cfg_ctrl_w :      // RULE7
                          wr_ctrl         ? ctrl_w : cfg_r.ctrl;
   wire [15:0] adv_nxt  = CONFIG_VALID_IN ? CONFIG_IN.adv :   // RULE7
                          wr_adv          ? wdata : cfg_r.adv;
   wire        rd_en_nxt = wr_gen ? wdata[`SPIER_GEN_RD_EN] : rd_en_r; // RULE4

   // Register bank.
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         cfg_r.ctrl <= `SPIER_CTRL_RESET;
         cfg_r.adv  <= `SPIER_ADV_RESET;
         rd_en_r    <= `SPIER_GEN_RESET; // RULE4
      end else begin
         cfg_r.ctrl <= ctrl_nxt;
         cfg_r.adv  <= adv_nxt;
         rd_en_r    <= rd_en_nxt;
      end
   end

   // Client interface and option outputs. The MAC-side variant has no
   // choice and always uses GMII.
   wire mac_side  = (VARIANT == SPIER_MAC_SIDE_VARIANT);
   wire gmii_sel  = mac_side | CLIENT_GMII;                       // RULE9 RULE10
   wire an_active = AN_INCL & cfg_r.ctrl[`SPIER_CTRL_AN_EN];      // RULE8

   // Option registers, so every top output starts at a flop.
   // They read zero during reset; the first edge after it loads the real
   // options, so a client must not sample them while reset is held.
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         CFG_OUT         <= '0;
         RD_CHECK_EN_OUT <= 1'b0;
         MAC_SIDE_OUT    <= 1'b0;
         CLIENT_GMII_OUT <= 1'b0;
         AN_ACTIVE_OUT   <= 1'b0;
      end else begin
         CFG_OUT         <= cfg_r;
         RD_CHECK_EN_OUT <= rd_en_r; // RULE5
         MAC_SIDE_OUT    <= mac_side;
         CLIENT_GMII_OUT <= gmii_sel;
         AN_ACTIVE_OUT   <= an_active;
      end
   end

   // Running disparity qualification.
   // The gate reads the bank bit, not RD_CHECK_EN_OUT, so the gated error
   // and the status output follow a write on the same clock edge.
   spier_rd_gate u_rd_gate (
      .clk_in     (CLOCK_IN),
      .resetn_in  (RESETN_IN),
      .enable_in  (rd_en_r),
      .rd_err_in  (RD_ERR_IN),
      .rd_err_out (RD_ERR_OUT)
   );

endmodule

// [design/spier_sync.sv]
/*
 * Three-stage synchroniser for pins from outside the clock domain.
 * A bit changes only once the second and third stages agree.
 */
`timescale 1ns/1ps
module spier_sync
   import spier_pkg::*;
#(
   parameter int W = 2
) (
   // Clock and reset.
   input  wire logic         clk_in,
   input  wire logic         resetn_in,
   // Raw and filtered levels.
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         logic s1_r;
         logic s2_r;
         logic s3_r;
         // Only the second stage reads the first, to keep it metastable-safe.
         always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
               q_out[i] <= 1'b0;
            end else begin
               s1_r <= d_in[i];
               s2_r <= s1_r;
               s3_r <= s2_r;
               q_out[i] <= (s2_r == s3_r) ? s3_r : q_out[i];
            end
         end
      end
   endgenerate

endmodule

// [sim/serial_phy_id_ext_regs_tb.sv]
/* Self-checking bench of the management register bank.
   Assumes the station model and the port checker beside it. */
`timescale 1ns/1ps
`include "spier_defs.svh"
module serial_phy_id_ext_regs_tb
   import spier_pkg::*;
;
   // Identity values are arbitrary.
   localparam logic [21:0] ORG = 22'h1b2c3;
   localparam logic [5:0]  MODEL = 6'h2a;
   localparam logic [3:0]  REV = 4'h9;
   localparam logic [4:0]  PHY = 5'h07;
   logic       clk, rst_n, mdc, sta_d, sta_drv, mdio_w, mdio_o, mdio_oe_n;
   logic       cfg_v, rd_err_in, rd_en, rd_err_out, mac, gmii, an;
   spier_cfg_t cfg, cfg_out;
   int         n_fail, check_count, cycles;

   // The wire is pulled up whenever nobody drives it.
   assign mdio_w = !mdio_oe_n ? mdio_o : (sta_drv ? sta_d : 1'b1);

   spier_regs #(.ORG_ID(ORG), .MODEL_ID(MODEL), .REV_ID(REV)) u_dut (
      .CLOCK_IN(clk), .RESETN_IN(rst_n), .MDC_IN(mdc), .MDIO_IN(mdio_w), .MDIO_OUT(mdio_o),
      .MDIO_OE_N_OUT(mdio_oe_n), .PHYAD_IN(PHY), .CONFIG_IN(cfg), .CONFIG_VALID_IN(cfg_v),
      .CFG_OUT(cfg_out), .RD_ERR_IN(rd_err_in), .RD_CHECK_EN_OUT(rd_en),
      .RD_ERR_OUT(rd_err_out), .MAC_SIDE_OUT(mac), .CLIENT_GMII_OUT(gmii), .AN_ACTIVE_OUT(an));
   spier_station u_sta (.clk_in(clk), .mdio_in(mdio_w), .mdc_out(mdc), .mdio_out(sta_d),
                        .drive_out(sta_drv));

   // Clock and hang guard; a whole run needs well under the ceiling.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         conclude();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic mrd(input logic [4:0] a, input logic [4:0] ra, output logic [15:0] d);
      u_sta.frame(`SPIER_OP_READ, a, ra, 16'h0, 6, d);
   endtask
   task automatic mwr(input logic [4:0] ra, input logic [15:0] wd, input int half);
      logic [15:0] dummy;
      u_sta.frame(`SPIER_OP_WRITE, PHY, ra, wd, half, dummy);
   endtask

   // Build options after reset.
   task automatic t_opts;
      chk("mac side", 32'h1, {31'h0, mac});
      chk("gmii", 32'h1, {31'h0, gmii});
      chk("autoneg", 32'h1, {31'h0, an});
   endtask
   // Constant registers read right and ignore writes of all ones.
   task automatic t_const;
      logic [4:0]  ra[3];
      logic [15:0] ex[3];
      logic [15:0] d;
      ra = '{`SPIER_REG_ID_HI, `SPIER_REG_ID_LO, `SPIER_REG_EXT};
      ex = '{ORG[21:6], {ORG[5:0], MODEL, REV}, 16'h8000};
      for (int k = 0; k < 3; k++) begin
         mrd(PHY, ra[k], d);
         chk("const reg", {16'h0, ex[k]}, {16'h0, d});
         mwr(ra[k], 16'hffff, 6);
         mrd(PHY, ra[k], d);
         chk("const reg after write", {16'h0, ex[k]}, {16'h0, d});
      end
   endtask
   // Disparity enable register and its effect on the error flag.
   task automatic rd_pulse(input logic exp);
      @(negedge clk);
      rd_err_in = 1'b1;
      @(negedge clk);
      chk("rd error", {31'h0, exp}, {31'h0, rd_err_out});
      rd_err_in = 1'b0;
   endtask
   task automatic t_gen;
      logic [15:0] d;
      mrd(PHY, `SPIER_REG_GEN, d);
      chk("gen reset", 32'h0, {16'h0, d});
      rd_pulse(1'b0);
      mwr(`SPIER_REG_GEN, 16'hffff, 6);
      mrd(PHY, `SPIER_REG_GEN, d);
      chk("gen set", 32'h1, {16'h0, d});
      rd_pulse(1'b1);
      mwr(`SPIER_REG_GEN, 16'h0000, 10);
      chk("gen clear", 32'h0, {31'h0, rd_en});
      rd_pulse(1'b0);
   endtask
   // Back-to-back config strobes, the first clearing auto-negotiation and
   // the second setting it again, then the value seen over management.
   task automatic t_cfg;
      logic [15:0] d;
      @(negedge clk);
      cfg = '{ctrl: 16'h0000, adv: 16'h1234};
      cfg_v = 1'b1;
      @(negedge clk);
      cfg = '{ctrl: 16'hffff, adv: 16'habcd};
      @(negedge clk);
      cfg_v = 1'b0;
      chk("cfg first", {`SPIER_CTRL_FIXED, 16'h1234}, cfg_out);
      chk("an off", 32'h0, {31'h0, an});
      @(negedge clk);
      chk("cfg second", {`SPIER_CTRL_WMASK | `SPIER_CTRL_FIXED, 16'habcd}, cfg_out);
      chk("an on", 32'h1, {31'h0, an});
      mrd(PHY, `SPIER_REG_ADV, d);
      chk("adv over mdio", 32'habcd, {16'h0, d});
   endtask
   // Foreign address gets no answer; unmapped register reads zero.
   task automatic t_refuse;
      logic [15:0] d;
      mrd(PHY + 5'h01, `SPIER_REG_EXT, d);
      chk("other phy", 32'hffff, {16'h0, d});
      mrd(PHY, 5'h1f, d);
      chk("unmapped", 32'h0, {16'h0, d});
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Main sequence.
   initial begin
      n_fail = 0;
      check_count = 0;
      cycles = 0;
      rst_n = 1'b0;
      cfg = '0;
      cfg_v = 1'b0;
      rd_err_in = 1'b0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      t_opts();
      t_const();
      t_gen();
      t_cfg();
      t_refuse();
      conclude();
   end
endmodule

// [sim/spier_regs_sva.sv]
/* Port checker of the management register bank.
   Assumes the default build options and one bind to the bank. */
`timescale 1ns/1ps
`include "spier_defs.svh"
module spier_regs_sva
   import spier_pkg::*;
(
   input wire logic       CLOCK_IN,
   input wire logic       RESETN_IN,
   input wire logic       MDIO_OUT,
   input wire logic       MDIO_OE_N_OUT,
   input wire spier_cfg_t CONFIG_IN,
   input wire logic       CONFIG_VALID_IN,
   input wire spier_cfg_t CFG_OUT,
   input wire logic       RD_ERR_IN,
   input wire logic       RD_CHECK_EN_OUT,
   input wire logic       RD_ERR_OUT,
   input wire logic       MAC_SIDE_OUT,
   input wire logic       CLIENT_GMII_OUT,
   input wire logic       AN_ACTIVE_OUT
);
   default clocking cb @(posedge CLOCK_IN);
   endclocking
   default disable iff (!RESETN_IN);

   // A read answer starts with a zero turnaround bit and then holds the wire for eight more clocks.
   sequence s_drive_hold;
      !MDIO_OUT ##1 (!MDIO_OE_N_OUT) [*8];
   endsequence
   // A config strobe shows up on the outputs two edges later, masked.
   sequence s_cfg_seen;
      ##2 CFG_OUT == {($past(CONFIG_IN.ctrl, 2) & `SPIER_CTRL_WMASK) | `SPIER_CTRL_FIXED,
                      $past(CONFIG_IN.adv, 2)};
   endsequence

   // The first edge after reset still shows reset values, hence the past guard.
   AST_RD_GATE: assert property (RD_ERR_OUT == (RD_CHECK_EN_OUT && $past(RD_ERR_IN)))
      else $error("disparity error passed with checking off");
   AST_RD_EN_SRC: assert property ($changed(RD_CHECK_EN_OUT) |-> MDIO_OE_N_OUT)
      else $error("disparity enable changed during a read answer");
   AST_DEFAULTS: assert property ($past(RESETN_IN) |-> MAC_SIDE_OUT && CLIENT_GMII_OUT)
      else $error("build defaults not reported");
   AST_MAC_GMII: assert property (MAC_SIDE_OUT |-> CLIENT_GMII_OUT)
      else $error("MAC side variant without GMII client");
   AST_AN_FOLLOW: assert property ($past(RESETN_IN) |-> AN_ACTIVE_OUT == CFG_OUT.ctrl[12])
      else $error("auto-negotiation state differs from control bit");
   AST_CFG_LOAD: assert property (CONFIG_VALID_IN |-> s_cfg_seen)
      else $error("config port value not loaded");
   AST_CFG_FIXED: assert property ($past(RESETN_IN) |->
      (CFG_OUT.ctrl & ~`SPIER_CTRL_WMASK) == `SPIER_CTRL_FIXED)
      else $error("fixed control bits wrong");
   AST_READ_DRIVE: assert property ($fell(MDIO_OE_N_OUT) |-> s_drive_hold)
      else $error("read answer not held on the wire");
endmodule

bind spier_regs spier_regs_sva u_sva (.CLOCK_IN(CLOCK_IN), .RESETN_IN(RESETN_IN),
   .MDIO_OUT(MDIO_OUT), .MDIO_OE_N_OUT(MDIO_OE_N_OUT), .CONFIG_IN(CONFIG_IN),
   .CONFIG_VALID_IN(CONFIG_VALID_IN), .CFG_OUT(CFG_OUT), .RD_ERR_IN(RD_ERR_IN),
   .RD_CHECK_EN_OUT(RD_CHECK_EN_OUT), .RD_ERR_OUT(RD_ERR_OUT), .MAC_SIDE_OUT(MAC_SIDE_OUT),
   .CLIENT_GMII_OUT(CLIENT_GMII_OUT), .AN_ACTIVE_OUT(AN_ACTIVE_OUT));

// [sim/spier_station.sv]
/* Station manager model that runs management frames.
   Assumes the bench resolves the wire with a pull-up. */
`timescale 1ns/1ps
module spier_station
(
   input  wire logic clk_in,
   input  wire logic mdio_in,
   output logic      mdc_out,
   output logic      mdio_out,
   output logic      drive_out
);
   // Clock stands low and the wire is released between frames.
   initial begin
      mdc_out = 1'b0;
      mdio_out = 1'b1;
      drive_out = 1'b0;
   end

   // One frame; half sets the management clock high time in system clocks, and the low time is one clock longer.
   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                        input logic [15:0] wd, input int half, output logic [15:0] rd);
      logic [35:0] bits;
      bits = {4'hf, 2'b01, op, phy, ra, 2'b10, wd};
      rd = 16'h0;
      for (int i = 35; i >= 0; i--) begin
         @(negedge clk_in);
         drive_out = !(op == 2'h2 && i <= 17); // Let go at turnaround on reads.
         mdio_out = bits[i];
         repeat (half) @(negedge clk_in);
         mdc_out = 1'b1;
         if (i < 16) rd[i] = mdio_in;
         repeat (half) @(negedge clk_in);
         mdc_out = 1'b0;
      end
      drive_out = 1'b0;
      mdio_out = 1'b1;
   endtask
endmodule
